// File: src/sram_ctrl_defines.vh
// Timing and width constants for the asynchronous static memory controller
`ifndef SRAM_CTRL_DEFINES_VH
`define SRAM_CTRL_DEFINES_VH
`define SYS_CLK_PERIOD_NS     20
`define ADDR_W                18
`define DATA_W                16
// Device timing figures in ns (slowest speed grade)
`define T_ADDR_SETUP_NS       0
`define T_WRITE_PULSE_NS      12
`define T_WRITE_DATA_SETUP_NS 8
`define T_WRITE_STROBE_TO_FLOAT_NS 8
`define T_ACCESS_NS           15
`define T_OE_FLOAT_NS         8
// Cycle counts: least times round up, never below one
`define CYC_CEIL(t) (((((t) + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS) < 1) ? 1 : \
  (((t) + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS))
`define WRITE_PULSE_CYC  `CYC_CEIL(`T_WRITE_PULSE_NS + `T_WRITE_DATA_SETUP_NS + \
  `T_WRITE_STROBE_TO_FLOAT_NS)
`define READ_ACCESS_CYC  `CYC_CEIL(`T_ACCESS_NS)
`define FLOAT_CYC        `CYC_CEIL(`T_OE_FLOAT_NS)
`define CNT_W            4
// State codes
`define ST_IDLE    3'h0
`define ST_RD      3'h1
`define ST_WR_SET  3'h2
`define ST_WR      3'h3
`define ST_WR_END  3'h4
`define ST_FLOAT   3'h5
`endif

// File: src/sync2.v
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter W = 1
) (
  input  wire         sys_clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] q_r;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= {W{1'b0}};
      q_r    <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end
  assign q_o = q_r;
endmodule // sync2
`default_nettype wire

// File: src/sram_ctrl.v
// Controller driving an asynchronous 16-bit static memory with correction flag
// Function
// - Write happens only while write, chip and a byte select overlap low.
// - Write starts when all strobes low; first rising strobe ends it.
// - Data setup and hold are kept around the strobe that ends write.
// - Write enable is held high during every read cycle.
// - Address is valid before chip select falls on a read.
// - Write pulse lasts at least data setup plus strobe-to-float time.
// - Controller never drives data while the memory may still drive it.
`timescale 1ns/1ns
`default_nettype none
`include "sram_ctrl_defines.vh"
module sram_ctrl #(
  parameter HAS_FLAG = 1
) (
  input  wire                 sys_clk_i,
  input  wire                 rst_i,
  input  wire                 req_valid_i,
  output wire                 req_ready_o,
  input  wire                 req_write_i,
  input  wire [`ADDR_W-1:0]   req_addr_i,
  input  wire [`DATA_W-1:0]   req_wdata_i,
  input  wire [1:0]           req_be_i,
  output wire                 rsp_valid_o,
  output wire [`DATA_W-1:0]   rsp_rdata_o,
  output wire                 rsp_corrected_o,
  output wire [`ADDR_W-1:0]   mem_addr_o,
  output wire                 mem_chip_sel_n_o,
  output wire                 mem_out_en_n_o,
  output wire                 mem_wr_en_n_o,
  output wire                 lower_byte_select_n_o,
  output wire                 upper_byte_select_n_o,
  input  wire [`DATA_W-1:0]   mem_data_i,
  output wire [`DATA_W-1:0]   mem_data_o,
  output wire [1:0]           mem_data_oe_o,
  input  wire                 mem_corr_flag_i
);
  reg  [2:0]          state_r;
  reg  [2:0]          state_nxt;
  reg  [`CNT_W-1:0]   cnt_r;
  reg  [`CNT_W-1:0]   cnt_nxt;
  reg  [`ADDR_W-1:0]  addr_r;
  reg  [`DATA_W-1:0]  wdata_r;
  reg  [1:0]          be_r;
  reg                 cs_n_r;
  reg                 oe_n_r;
  reg                 we_n_r;
  reg  [1:0]          bsel_n_r;
  reg  [1:0]          doe_r;
  reg                 rsp_valid_r;
  reg  [`DATA_W-1:0]  rdata_r;
  reg                 corr_r;
  wire [`DATA_W-1:0]  data_sync;
  wire                flag_sync;
  wire                take;
  wire [`DATA_W-1:0]  lane_mask;
  wire [`CNT_W-1:0]   wr_load;
  wire [`CNT_W-1:0]   rd_load;
  wire [`CNT_W-1:0]   flt_load;

  // Counter loads are worked out wide and cut to the counter width on purpose
  localparam [31:0] WR_LOAD_W  = `WRITE_PULSE_CYC;
  // Two extra cycles cover the resampling flops on the read data
  localparam [31:0] RD_LOAD_W  = `READ_ACCESS_CYC + 2;
  localparam [31:0] FLT_LOAD_W = `FLOAT_CYC;
  assign wr_load  = WR_LOAD_W[`CNT_W-1:0];
  assign rd_load  = RD_LOAD_W[`CNT_W-1:0];
  assign flt_load = FLT_LOAD_W[`CNT_W-1:0];

  // Read data and flag come from another timing domain; resample before use
  // The bus holds still for the whole access, so per-bit resampling cannot tear a word
  sync2 #(.W(`DATA_W + 1)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       ({mem_corr_flag_i, mem_data_i}),
    .q_o       ({flag_sync, data_sync})
  );

  // Only one access in flight; a request while busy is simply not taken
  assign req_ready_o = (state_r == `ST_IDLE);
  assign take        = req_valid_i && req_ready_o && (req_be_i != 2'h0);

  // One mask slice per byte lane; an unselected lane reads back as zero
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{be_r[lane]}};
    end
  endgenerate

  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      `ST_IDLE: begin
        if (take) begin
          state_nxt = req_write_i ? `ST_WR_SET : `ST_RD;
          cnt_nxt   = req_write_i ? wr_load : rd_load;
        end
      end
      `ST_RD: begin
        if (cnt_r == {`CNT_W{1'b0}}) begin
          // Memory may still drive the lanes for its turn-off time after a read
          state_nxt = `ST_FLOAT;
          cnt_nxt   = flt_load;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      // One setup cycle: selects and data settle before the write strobe falls
      `ST_WR_SET: state_nxt = `ST_WR;
      `ST_WR: begin
        if (cnt_r == {`CNT_W{1'b0}}) begin
          state_nxt = `ST_WR_END;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      `ST_WR_END: state_nxt = `ST_IDLE;
      `ST_FLOAT: begin
        if (cnt_r == {`CNT_W{1'b0}}) begin
          state_nxt = `ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: state_nxt = `ST_IDLE;
    endcase
  end

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r     <= `ST_IDLE;
      cnt_r       <= {`CNT_W{1'b0}};
      addr_r      <= {`ADDR_W{1'b0}};
      wdata_r     <= {`DATA_W{1'b0}};
      be_r        <= 2'h0;
      cs_n_r      <= 1'b1;
      oe_n_r      <= 1'b1;
      we_n_r      <= 1'b1;
      bsel_n_r    <= 2'h3;
      doe_r       <= 2'h0;
      rsp_valid_r <= 1'b0;
      rdata_r     <= {`DATA_W{1'b0}};
      corr_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      rsp_valid_r <= 1'b0;
      case (state_r)
        `ST_IDLE: begin
          if (take) begin
            // Request is copied so the pins hold still while the caller moves on
            // Address settles before any strobe falls
            addr_r  <= req_addr_i;
            wdata_r <= req_wdata_i;
            be_r    <= req_be_i;
          end
        end
        `ST_RD: begin
          cs_n_r   <= 1'b0;
          we_n_r   <= 1'b1;
          oe_n_r   <= 1'b0;
          bsel_n_r <= ~be_r;
          if (cnt_r == {`CNT_W{1'b0}}) begin
            rdata_r     <= data_sync & lane_mask;
            // Flag is sampled only while a read is active, so float is never seen
            corr_r      <= (HAS_FLAG != 0) ? flag_sync : 1'b0;
            rsp_valid_r <= 1'b1;
            // Strobes rise together so the lanes float before the next access
            cs_n_r      <= 1'b1;
            oe_n_r      <= 1'b1;
            bsel_n_r    <= 2'h3;
          end
        end
        `ST_WR_SET: begin
          // Output enable stays high so the memory never drives during a write
          oe_n_r   <= 1'b1;
          cs_n_r   <= 1'b0;
          bsel_n_r <= ~be_r;
          doe_r    <= be_r;
        end
        `ST_WR: begin
          we_n_r <= 1'b0;
          if (cnt_r == {`CNT_W{1'b0}}) begin
            we_n_r <= 1'b1;
          end
        end
        `ST_WR_END: begin
          // Data held one cycle past the rising write strobe
          cs_n_r   <= 1'b1;
          bsel_n_r <= 2'h3;
          doe_r    <= 2'h0;
        end
        default: begin
          // Float wait and any stray code drive chip select, output enable and write enable high; byte selects are left as they are
          cs_n_r <= 1'b1;
          oe_n_r <= 1'b1;
          we_n_r <= 1'b1;
        end
      endcase
    end
  end

  assign mem_addr_o            = addr_r;
  assign mem_chip_sel_n_o      = cs_n_r;
  assign mem_out_en_n_o        = oe_n_r;
  assign mem_wr_en_n_o         = we_n_r;
  assign lower_byte_select_n_o = bsel_n_r[0];
  assign upper_byte_select_n_o = bsel_n_r[1];
  assign mem_data_o            = wdata_r;
  assign mem_data_oe_o         = doe_r;
  assign rsp_valid_o           = rsp_valid_r;
  assign rsp_rdata_o           = rdata_r;
  assign rsp_corrected_o       = corr_r;
endmodule // sram_ctrl
`default_nettype wire

// File: test/sram_model.sv
// Behavioural static memory with correction flag
`timescale 1ns/1ns
`default_nettype none
module sram_model #(
  parameter logic [17:0] ERR_ADDR = 18'h3FFFF
) (
  input  wire logic [17:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  bsel_n_i,
  input  wire logic [15:0] data_i,
  output wire logic [15:0] q_o,
  output wire logic [1:0]  q_en_o,
  output wire logic        flag_o
);
  logic [15:0] mem [0:262143];
  logic [15:0] din, last;
  logic [1:0]  lanes;
  logic        flast;
  wire wr = !cs_n_i && !we_n_i && bsel_n_i != 2'h3;
  wire rd = !cs_n_i && !oe_n_i && we_n_i;
  wire [15:0] m = {{8{q_en_o[1]}}, {8{q_en_o[0]}}};
  // Released lanes show the inverse of the last value, never a fixed level
  always @* begin
    if (wr) begin
      lanes = ~bsel_n_i;
      din = data_i;
    end
    if (rd) begin
      last = mem[addr_i];
      flast = addr_i == ERR_ADDR;
    end
  end
  // Store happens as the overlap ends, whichever strobe ends it
  always @(negedge wr) begin
    if (lanes[0]) mem[addr_i][7:0] = din[7:0];
    if (lanes[1]) mem[addr_i][15:8] = din[15:8];
  end
  assign q_en_o = rd ? ~bsel_n_i : 2'h0;
  assign q_o = (mem[addr_i] & m) | (~last & ~m);
  assign flag_o = rd ? addr_i == ERR_ADDR : ~flast;
endmodule // sram_model
`default_nettype wire

// File: test/sram_ctrl_chk.sv
// Protocol checker for the static memory controller pins
`timescale 1ns/1ns
`default_nettype none
module sram_ctrl_chk (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        req_valid_i,
  input wire logic        req_ready_o,
  input wire logic        req_write_i,
  input wire logic [1:0]  req_be_i,
  input wire logic        rsp_valid_o,
  input wire logic [17:0] mem_addr_o,
  input wire logic        mem_chip_sel_n_o,
  input wire logic        mem_out_en_n_o,
  input wire logic        mem_wr_en_n_o,
  input wire logic        lower_byte_select_n_o,
  input wire logic        upper_byte_select_n_o,
  input wire logic [15:0] mem_data_o,
  input wire logic [1:0]  mem_data_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  rd_we_high_a: assert property (!mem_out_en_n_o |-> mem_wr_en_n_o)
    else $error("write strobe low while outputs enabled");
  no_contend_a: assert property (|mem_data_oe_o |->
    mem_chip_sel_n_o || mem_out_en_n_o || !mem_wr_en_n_o)
    else $error("data driven while memory drives");
  wr_strobes_a: assert property (!mem_wr_en_n_o |-> !mem_chip_sel_n_o &&
    !(lower_byte_select_n_o && upper_byte_select_n_o))
    else $error("write strobe without select");
  wr_lanes_a: assert property (!mem_wr_en_n_o |->
    mem_data_oe_o == ~{upper_byte_select_n_o, lower_byte_select_n_o})
    else $error("driven lanes differ from selects");
  wr_hold_a: assert property ($rose(mem_wr_en_n_o) |-> $stable(mem_data_o) &&
    $stable(mem_data_oe_o) && $stable(mem_addr_o))
    else $error("data or address moved at write end");
  wr_pulse_a: assert property ($fell(mem_wr_en_n_o) |->
    !mem_wr_en_n_o [*2] ##1 mem_wr_en_n_o)
    else $error("write pulse length wrong");
  addr_hold_a: assert property (!mem_chip_sel_n_o && $past(!mem_chip_sel_n_o)
    |-> $stable(mem_addr_o))
    else $error("address moved while selected");
  rd_latency_a: assert property (req_valid_i && req_ready_o && !req_write_i &&
    req_be_i != 2'h0 |-> ##5 rsp_valid_o)
    else $error("read answer late or missing");
endmodule // sram_ctrl_chk
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the static memory controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        sys_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
  logic [17:0] req_addr_i = 18'h00000;
  logic [15:0] req_wdata_i = 16'h0000;
  logic [1:0]  req_be_i = 2'h0;
  wire         rdy, rsp_v, corr, corr_nf, cs_n, oe_n, we_n, lb_n, ub_n, flag;
  wire  [15:0] rdata, dout, q, bus;
  wire  [17:0] addr;
  wire  [1:0]  doe, q_en;
  int          failures = 0, comparisons = 0, i, n;
  logic [53:0] r;
  // Row: write, address, data, byte enables, expected data, expected flag
  localparam logic [53:0] ROWS [9] = '{
    {1'b1, 18'h00010, 16'h1234, 2'h3, 16'h0000, 1'b0},
    {1'b0, 18'h00010, 16'h0000, 2'h3, 16'h1234, 1'b0},
    {1'b1, 18'h00010, 16'hABCD, 2'h1, 16'h0000, 1'b0},
    {1'b0, 18'h00010, 16'h0000, 2'h3, 16'h12CD, 1'b0},
    {1'b1, 18'h00010, 16'h5600, 2'h2, 16'h0000, 1'b0},
    {1'b0, 18'h00010, 16'h0000, 2'h2, 16'h5600, 1'b0},
    {1'b0, 18'h00010, 16'h0000, 2'h1, 16'h00CD, 1'b0},
    {1'b1, 18'h3FFFF, 16'hBEEF, 2'h3, 16'h0000, 1'b0},
    {1'b0, 18'h3FFFF, 16'h0000, 2'h3, 16'hBEEF, 1'b1}};
  assign bus = {doe[1] ? dout[15:8] : q[15:8], doe[0] ? dout[7:0] : q[7:0]};
  sram_ctrl #(.HAS_FLAG(1)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_ready_o(rdy), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_be_i(req_be_i),
    .rsp_valid_o(rsp_v), .rsp_rdata_o(rdata), .rsp_corrected_o(corr),
    .mem_addr_o(addr), .mem_chip_sel_n_o(cs_n), .mem_out_en_n_o(oe_n),
    .mem_wr_en_n_o(we_n), .lower_byte_select_n_o(lb_n),
    .upper_byte_select_n_o(ub_n), .mem_data_i(bus), .mem_data_o(dout),
    .mem_data_oe_o(doe), .mem_corr_flag_i(flag));
  sram_model mem (.addr_i(addr), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .bsel_n_i({ub_n, lb_n}), .data_i(bus), .q_o(q), .q_en_o(q_en), .flag_o(flag));
  // Build without the flag pin sees the same pins and must never report a correction
  sram_ctrl #(.HAS_FLAG(0)) dut_nf (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_ready_o(), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_be_i(req_be_i),
    .rsp_valid_o(), .rsp_rdata_o(), .rsp_corrected_o(corr_nf),
    .mem_addr_o(), .mem_chip_sel_n_o(), .mem_out_en_n_o(), .mem_wr_en_n_o(),
    .lower_byte_select_n_o(), .upper_byte_select_n_o(), .mem_data_i(bus),
    .mem_data_o(), .mem_data_oe_o(), .mem_corr_flag_i(flag));
  always #10 sys_clk_i = ~sys_clk_i;
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task op(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
    n = 0;
    @(negedge sys_clk_i);
    while (rdy !== 1'b1 && n < 50) begin
      @(negedge sys_clk_i);
      n++;
    end
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_be_i} = {1'b1, w, a, d, be};
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    while (!w && rsp_v !== 1'b1 && n < 50) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    if (n >= 50) failures++;
  endtask
  task end_sim;
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge sys_clk_i);
    chk({10'h000, cs_n, oe_n, we_n, lb_n, ub_n, |doe}, 16'h003E);
    rst_i = 1'b0;
    $display("Test reset done");
    for (i = 0; i < 9; i++) begin
      r = ROWS[i];
      op(r[53], r[52:35], r[34:19], r[18:17]);
      if (!r[53]) chk(rdata, r[16:1]);
      if (!r[53]) chk({15'h0000, corr}, {15'h0000, r[0]});
      if (!r[53]) chk({15'h0000, corr_nf}, 16'h0000);
    end
    $display("Test table done");
    @(negedge sys_clk_i);
    {req_valid_i, req_write_i, req_be_i} = {1'b1, 1'b1, 2'h0};
    repeat (4) @(negedge sys_clk_i);
    chk({15'h0000, cs_n & we_n}, 16'h0001);
    req_valid_i = 1'b0;
    $display("Test empty enables done");
    // Reset cut into a write before its strobe falls; the pins must go idle at once
    op(1'b1, 18'h00020, 16'h7777, 2'h3);
    @(negedge sys_clk_i);
    rst_i = 1'b1;
    #1 chk({10'h000, cs_n, oe_n, we_n, lb_n, ub_n, |doe}, 16'h003E);
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    op(1'b0, 18'h00010, 16'h0000, 2'h3);
    chk(rdata, 16'h56CD);
    chk({15'h0000, corr}, 16'h0000);
    $display("Test mid reset done");
    end_sim;
  end
  initial begin
    #100000;
    failures++;
    end_sim;
  end
endmodule // testbench
bind sram_ctrl sram_ctrl_chk chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i),
  .req_be_i(req_be_i), .rsp_valid_o(rsp_valid_o), .mem_addr_o(mem_addr_o),
  .mem_chip_sel_n_o(mem_chip_sel_n_o), .mem_out_en_n_o(mem_out_en_n_o),
  .mem_wr_en_n_o(mem_wr_en_n_o), .lower_byte_select_n_o(lower_byte_select_n_o),
  .upper_byte_select_n_o(upper_byte_select_n_o), .mem_data_o(mem_data_o),
  .mem_data_oe_o(mem_data_oe_o));
`default_nettype wire
